// ==== common/ldo_ctrl_defines.svh ====
// Purpose: offsets, field positions, reset values and figures for the LDO control block
// Assumes: Avalon-MM byte addressing, one 32-bit word per register
// Notes: included by the package, the control and fault logic and the bench files; the mode decoder does not include it
// Function
// - With protection enabled, an over-current clears that LDO's enable bit and sets its fault flag together.
// - With protection disabled, an over-current LDO stays enabled and runs current limited.
// - Every overload on a current-limited LDO that is on sets the fault flag whatever the protection enable holds.
// - The protection enable resets to cleared.
// - Each fault flag has a mask bit that keeps it off the interrupt when set.
// - A switchable LDO in load-switch mode gets no current limiting.
// - Load-switch mode drives the pass device fully on but still soft-starts at turn-on.
// - The fixed LDO voltage is a 4-bit code from 1.80 V at 0000 to 3.30 V at 1111 in 0.1 V steps.
// - The fixed LDO goes low power only in Standby or Sleep and only with its low-power bit set.
// - The fixed LDO decodes off, on, low power from enable, standby keep, sleep keep, low power and state.
// - The fixed LDO discharge pulldown is on while disabled and while the host reset output is low.
// - The backup supply takes the rail above the upper threshold and the cell below the lower one, cell only if enabled.
// - Losing the rail with a cell present and enabled turns the backup supply into a pass switch.
// - The switchable LDOs use the same mode decoding as the fixed LDO.
`ifndef LDO_CTRL_DEFINES_SVH
`define LDO_CTRL_DEFINES_SVH

// -----------------------------------------------------------------
// register map
// -----------------------------------------------------------------
`define ADDR_W 5
`define REG_CTRL 5'h00
`define REG_SW_A 5'h04
`define REG_SW_B 5'h08
`define REG_FIXED 5'h0c
`define REG_FAULT 5'h10
`define REG_MASK 5'h14
`define REG_STATUS 5'h18

// -----------------------------------------------------------------
// fields
// -----------------------------------------------------------------
`define NUM_LDO 3
`define IDX_SW_A 0
`define IDX_SW_B 1
`define IDX_FIX 2
`define CFG_W 5
`define CFG_EN 0
`define CFG_STBY 1
`define CFG_SLEEP 2
`define CFG_LPWR 3
`define CFG_BYPASS 4
`define VCODE_LSB 4
`define VCODE_MSB 7
`define CTRL_SCP 0
`define CTRL_CELL 1
`define ST_ON_LSB 0
`define ST_LP_LSB 4
`define ST_LIM_LSB 8
`define ST_OC_LSB 12
`define ST_SRC_LSB 16
`define ST_MV_LSB 20

// -----------------------------------------------------------------
// reset values and figures
// -----------------------------------------------------------------
`define CFG_RST 5'h00
`define VCODE_RST 4'h0
`define MASK_RST 3'h0
`define VBASE_MV 12'h708
`define VSTEP_MV 12'h064
`define VCODE_MAX 4'hf
`define VTOP_MV 12'hce4

`endif

// ==== common/ldo_ctrl_pkg.sv ====
// Purpose: types of the LDO control block
// Assumes: ldo_ctrl_defines.svh gives the widths
// Notes: the whole state of the top module is one packed struct
`include "ldo_ctrl_defines.svh"
package ldo_ctrl_pkg;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STANDBY = 2'b01,
    ST_SLEEP = 2'b10
  } pmic_state_t;

  typedef enum logic [1:0] {
    BK_OFF = 2'b00,
    BK_RAIL = 2'b01,
    BK_CELL = 2'b10
  } backup_src_t;

  typedef struct packed {
    logic scp_en;
    logic cell_en;
    logic [`NUM_LDO-1:0][`CFG_W-1:0] cfg;
    logic [3:0] vcode;
    logic [`NUM_LDO-1:0] fault;
    logic [`NUM_LDO-1:0] mask;
    logic [`NUM_LDO-1:0] on;
    logic [`NUM_LDO-1:0] lp;
    logic [`NUM_LDO-1:0] soft_start;
    logic [`NUM_LDO-1:0] cur_lim;
    logic [`NUM_LDO-1:0] full_on;
    logic [`NUM_LDO-1:0] discharge;
    backup_src_t backup_src;
    logic [11:0] mv;
    logic ack;
    logic [31:0] rdata;
    logic irq;
  } state_t;

endpackage

// ==== verilog/ldo_mode_decode.sv ====
// Purpose: operating mode of one LDO from its control bits and the device state
// Assumes: state input is one of run, standby, sleep
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module ldo_mode_decode
  import ldo_ctrl_pkg::*;
(
  input wire logic enable,
  input wire logic standby_keep,
  input wire logic sleep_keep,
  input wire logic low_power,
  input wire pmic_state_t pmic_state,
  output logic on,
  output logic low_power_active
);

  // low power only counts where the state lets the regulator stay up
  always_comb begin
    on = 1'b0;
    low_power_active = 1'b0;
    case (pmic_state)
      ST_RUN: begin
        on = enable;
      end
      ST_STANDBY: begin
        on = enable & standby_keep;
        low_power_active = enable & standby_keep & low_power;
      end
      ST_SLEEP: begin
        on = enable & sleep_keep;
        low_power_active = enable & sleep_keep & low_power;
      end
      default: begin
        on = 1'b0;
      end
    endcase
  end

endmodule // ldo_mode_decode
`default_nettype wire

// ==== verilog/ldo_control_fault_logic.sv ====
// Purpose: control, fault and backup-supply logic for the two switchable and one fixed LDO
// Assumes: over-current, threshold and state inputs are synchronous to core_clk
// Notes: Avalon-MM slave with one wait state; fault register clears on read
`timescale 1ns/1ps
`default_nettype none
`include "ldo_ctrl_defines.svh"
module ldo_control_fault_logic
  import ldo_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire pmic_state_t pmic_state,
  input wire logic [`NUM_LDO-1:0] over_current,
  input wire logic host_reset_output_n,
  input wire logic rail_above_upper,
  input wire logic rail_below_lower,
  input wire logic backup_cell_present,
  output logic [`NUM_LDO-1:0] ldo_on,
  output logic [`NUM_LDO-1:0] ldo_low_power,
  output logic [`NUM_LDO-1:0] current_limit_en,
  output logic [`NUM_LDO-1:0] pass_full_on,
  output logic [`NUM_LDO-1:0] soft_start_pulse,
  output logic [`NUM_LDO-1:0] ldo_discharge,
  output logic [3:0] fixed_ldo_voltage_code,
  output logic [11:0] fixed_ldo_millivolt,
  output logic backup_from_rail,
  output logic backup_from_cell,
  output logic backup_switch_mode,
  output logic irq
);

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [11:0] code_to_mv(input logic [3:0] code);
    logic [11:0] step;
    step = `VSTEP_MV * {8'h00, code};
    return `VBASE_MV + step;
  endfunction

  function automatic logic [31:0] cfg_word(input logic [`CFG_W-1:0] c);
    return {27'h000_0000, c};
  endfunction

  state_t s_q;
  state_t s_d;
  logic [`NUM_LDO-1:0] dec_on;
  logic [`NUM_LDO-1:0] dec_lp;
  logic [`NUM_LDO-1:0] oc_eff;
  logic acc_wr;
  logic acc_rd;
  logic [31:0] status_word;

  // -----------------------------------------------------------------
  // mode decoders, one per regulator
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_LDO; g++) begin : g_dec
      ldo_mode_decode u_dec (
        .enable(s_q.cfg[g][`CFG_EN]),
        .standby_keep(s_q.cfg[g][`CFG_STBY]),
        .sleep_keep(s_q.cfg[g][`CFG_SLEEP]),
        .low_power(s_q.cfg[g][`CFG_LPWR]),
        .pmic_state(pmic_state),
        .on(dec_on[g]),
        .low_power_active(dec_lp[g])
      );
    end
  endgenerate

  // -----------------------------------------------------------------
  // bus handshake
  // -----------------------------------------------------------------
  // one wait state gives the read mux a full cycle before data is taken
  assign waitrequest = (read | write) & ~s_q.ack;
  assign acc_wr = write & s_q.ack;
  assign acc_rd = read & s_q.ack;
  // overload seen only where the limiter is active and the regulator up
  assign oc_eff = over_current & s_q.cur_lim & s_q.on;

  assign status_word = {
    s_q.mv,
    2'b00, s_q.backup_src,
    1'b0, over_current,
    1'b0, s_q.cur_lim,
    1'b0, s_q.lp,
    1'b0, s_q.on
  };

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ack = (read | write) & ~s_q.ack;
    // read data is captured in the wait cycle and stands at the accept edge
    if (read & ~s_q.ack) begin
      case (address)
        `REG_CTRL: s_d.rdata = {30'h0000_0000, s_q.cell_en, s_q.scp_en};
        `REG_SW_A: s_d.rdata = cfg_word(s_q.cfg[`IDX_SW_A]);
        `REG_SW_B: s_d.rdata = cfg_word(s_q.cfg[`IDX_SW_B]);
        `REG_FIXED: s_d.rdata = {24'h00_0000, s_q.vcode, s_q.cfg[`IDX_FIX][3:0]};
        `REG_FAULT: s_d.rdata = {29'h0000_0000, s_q.fault};
        `REG_MASK: s_d.rdata = {29'h0000_0000, s_q.mask};
        `REG_STATUS: s_d.rdata = status_word;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    // software writes; unmapped and read-only offsets are ignored
    if (acc_wr) begin
      case (address)
        `REG_CTRL: begin
          s_d.scp_en = writedata[`CTRL_SCP];
          s_d.cell_en = writedata[`CTRL_CELL];
        end
        `REG_SW_A: s_d.cfg[`IDX_SW_A] = writedata[`CFG_W-1:0];
        `REG_SW_B: s_d.cfg[`IDX_SW_B] = writedata[`CFG_W-1:0];
        `REG_FIXED: begin
          s_d.cfg[`IDX_FIX] = {1'b0, writedata[`CFG_LPWR:0]}; // no bypass on the fixed LDO
          s_d.vcode = writedata[`VCODE_MSB:`VCODE_LSB];
        end
        `REG_MASK: s_d.mask = writedata[`NUM_LDO-1:0];
        default: begin
        end
      endcase
    end
    // read clears the flags, a fresh overload in the same cycle still lands
    // only the flags the reader was shown are cleared, so a flag that
    // landed during the wait cycle survives for the next read
    if (acc_rd && address == `REG_FAULT) begin
      s_d.fault = s_q.fault & ~s_q.rdata[`NUM_LDO-1:0];
    end
    s_d.fault = s_d.fault | oc_eff;
    // protective disable overrides a software write in the same cycle
    for (int i = 0; i < `NUM_LDO; i++) begin
      if (s_q.scp_en && oc_eff[i]) begin
        s_d.cfg[i][`CFG_EN] = 1'b0;
      end
    end
    // regulator outputs follow the decoded mode
    s_d.on = dec_on;
    s_d.lp = dec_lp;
    s_d.soft_start = dec_on & ~s_q.on;
    for (int i = 0; i < `NUM_LDO; i++) begin
      s_d.cur_lim[i] = ~s_q.cfg[i][`CFG_BYPASS];
      s_d.full_on[i] = dec_on[i] & s_q.cfg[i][`CFG_BYPASS];
    end
    s_d.discharge = ~dec_on;
    s_d.discharge[`IDX_FIX] = ~dec_on[`IDX_FIX] | ~host_reset_output_n;
    s_d.mv = code_to_mv(s_q.vcode);
    s_d.irq = |(s_d.fault & ~s_d.mask);
    // backup source with hysteresis between the two thresholds
    case (s_q.backup_src)
      BK_RAIL: begin
        if (rail_below_lower) begin
          s_d.backup_src = (s_q.cell_en & backup_cell_present) ? BK_CELL : BK_OFF;
        end
      end
      BK_CELL: begin
        if (rail_above_upper) begin
          s_d.backup_src = BK_RAIL;
        end else if (!s_q.cell_en || !backup_cell_present) begin
          s_d.backup_src = BK_OFF;
        end
      end
      BK_OFF: begin
        if (rail_above_upper) begin
          s_d.backup_src = BK_RAIL;
        end else if (rail_below_lower && s_q.cell_en && backup_cell_present) begin
          s_d.backup_src = BK_CELL;
        end
      end
      default: s_d.backup_src = BK_OFF;
    endcase
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.cfg <= {`CFG_RST, `CFG_RST, `CFG_RST};
      s_q.vcode <= `VCODE_RST;
      s_q.mask <= `MASK_RST;
      s_q.cur_lim <= '1;
      s_q.discharge <= '1;
      s_q.mv <= `VBASE_MV;
      s_q.backup_src <= BK_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign readdata = s_q.rdata;
  assign ldo_on = s_q.on;
  assign ldo_low_power = s_q.lp;
  assign current_limit_en = s_q.cur_lim;
  assign pass_full_on = s_q.full_on;
  assign soft_start_pulse = s_q.soft_start;
  assign ldo_discharge = s_q.discharge;
  assign fixed_ldo_voltage_code = s_q.vcode;
  assign fixed_ldo_millivolt = s_q.mv;
  assign backup_from_rail = (s_q.backup_src == BK_RAIL);
  assign backup_from_cell = (s_q.backup_src == BK_CELL);
  assign backup_switch_mode = (s_q.backup_src == BK_CELL);
  assign irq = s_q.irq;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_scp_disable_en: assert property (s_q.scp_en && oc_eff[0] |=> !s_q.cfg[0][`CFG_EN] && s_q.fault[0])
    else $error("protected overload did not disable and flag");
  a_no_scp_keep: assert property (
    !s_q.scp_en && oc_eff[0] && s_q.cfg[0][`CFG_EN] && !acc_wr |=> s_q.cfg[0][`CFG_EN])
    else $error("unprotected overload changed enable");
  a_fault_always: assert property (oc_eff[1] |=> s_q.fault[1])
    else $error("overload did not set fault");
  a_fault_sticky: assert property (s_q.fault[0] && !(acc_rd && address == `REG_FAULT) |=> s_q.fault[0])
    else $error("fault dropped without a read");
  a_mask_irq: assert property (s_q.irq == |(s_q.fault & ~s_q.mask))
    else $error("interrupt disagrees with masked flags");
  a_bypass_nolim: assert property (s_q.cfg[0][`CFG_BYPASS] |=> !s_q.cur_lim[0])
    else $error("current limit active in load-switch mode");
  a_soft_start: assert property ($rose(s_q.on[1]) |-> s_q.soft_start[1])
    else $error("no soft start at turn-on");
  a_voltage_code: assert property (##1 s_q.mv == `VBASE_MV + `VSTEP_MV * {8'h00, $past(s_q.vcode)})
    else $error("voltage code mapping wrong");
  a_lp_state: assert property (pmic_state == ST_RUN |=> !s_q.lp[2])
    else $error("low power in run state");
  a_fixed_off: assert property (!s_q.cfg[2][`CFG_EN] |=> !s_q.on[2] && s_q.discharge[2])
    else $error("disabled fixed LDO not off");
  a_reset_pull: assert property (!host_reset_output_n |=> s_q.discharge[2])
    else $error("pulldown off during host reset");
  a_sw_decode: assert property (pmic_state == ST_SLEEP && !s_q.cfg[0][`CFG_SLEEP] |=> !s_q.on[0])
    else $error("switchable LDO on in sleep without keep");
  a_rail_src: assert property (rail_above_upper |=> backup_from_rail)
    else $error("rail not chosen above threshold");
  a_cell_gate: assert property (backup_from_cell |-> $past(s_q.cell_en))
    else $error("cell used while disabled");
  a_switch_mode: assert property (backup_from_rail && rail_below_lower && s_q.cell_en && backup_cell_present
                                  |=> backup_switch_mode)
    else $error("no switch mode after rail loss");

  // protective disable, and the limiter that stays when protection is off
  a_scp_off_later: assert property (
    s_q.scp_en && oc_eff[0] |=> ##1 !s_q.on[0])
    else $error("protected overload left regulator on");
  a_scp_fix: assert property (
    s_q.scp_en && oc_eff[`IDX_FIX] |=> !s_q.cfg[`IDX_FIX][`CFG_EN] && s_q.fault[`IDX_FIX])
    else $error("protected overload missed on fixed LDO");
  a_limit_kept: assert property (
    !s_q.scp_en && oc_eff[0] && !s_q.cfg[0][`CFG_BYPASS] |=> s_q.cur_lim[0])
    else $error("limiter dropped on unprotected overload");

  // flags, reset value of the protection bit and interrupt masking
  a_fault_swa: assert property (
    oc_eff[0] |=> s_q.fault[0])
    else $error("overload did not set switchable flag");
  a_fault_fix: assert property (
    oc_eff[`IDX_FIX] |=> s_q.fault[`IDX_FIX])
    else $error("overload did not set fixed flag");
  a_scp_reset: assert property (
    @(posedge core_clk) disable iff (1'b0) rst |=> !s_q.scp_en)
    else $error("protection enabled out of reset");
  a_irq_masked: assert property (
    s_q.fault[0] && s_q.mask[0] && !(|s_q.fault[2:1]) |-> !s_q.irq)
    else $error("masked flag raised interrupt");
  a_irq_unmasked: assert property (
    |(s_q.fault & ~s_q.mask) |-> s_q.irq)
    else $error("unmasked flag without interrupt");

  // load switch: limiter only outside it, pass device full on, one soft-start pulse
  a_limit_sw: assert property (
    !s_q.cfg[1][`CFG_BYPASS] |=> s_q.cur_lim[1])
    else $error("limiter off outside load-switch mode");
  a_bypass_full: assert property (
    s_q.cfg[1][`CFG_BYPASS] && dec_on[1] |=> s_q.full_on[1])
    else $error("load switch not fully on");
  a_soft_once: assert property (
    s_q.soft_start[1] |=> !s_q.soft_start[1])
    else $error("soft-start pulse too long");

  // voltage code end point and mode decoding of the fixed regulator
  a_mv_top: assert property (
    s_q.vcode == `VCODE_MAX |=> s_q.mv == `VTOP_MV)
    else $error("top voltage code maps wrong");
  a_sleep_lp: assert property (
    pmic_state == ST_SLEEP && &s_q.cfg[`IDX_FIX][`CFG_LPWR:`CFG_SLEEP]
    && s_q.cfg[`IDX_FIX][`CFG_EN] |=> s_q.lp[`IDX_FIX])
    else $error("no low power in sleep");
  a_run_on: assert property (
    pmic_state == ST_RUN && s_q.cfg[`IDX_FIX][`CFG_EN] |=> s_q.on[`IDX_FIX])
    else $error("enabled fixed LDO off in run");
  a_standby_off: assert property (
    pmic_state == ST_STANDBY && !s_q.cfg[`IDX_FIX][`CFG_STBY] |=> !s_q.on[`IDX_FIX])
    else $error("fixed LDO on in standby without keep");
  a_discharge_off: assert property (
    !s_q.on[`IDX_FIX] |-> s_q.discharge[`IDX_FIX])
    else $error("pulldown off while fixed LDO off");

  // backup source and flag clearing
  a_cell_present: assert property (
    backup_from_cell |-> $past(backup_cell_present))
    else $error("cell used while absent");
  a_rail_low_off: assert property (
    backup_from_rail && rail_below_lower && !s_q.cell_en
    |=> !backup_from_rail && !backup_from_cell)
    else $error("backup source kept after rail loss");
  a_fault_hold_fix: assert property (
    s_q.fault[`IDX_FIX] && !acc_rd |=> s_q.fault[`IDX_FIX])
    else $error("fixed flag dropped without a read");
  a_read_clear: assert property (
    acc_rd && address == `REG_FAULT && s_q.rdata[0] && !oc_eff[0] |=> !s_q.fault[0])
    else $error("reported flag not cleared by read");

  // switchable regulators share the decoding of the fixed one
  a_lp_needs_on: assert property (
    s_q.lp[0] |-> s_q.on[0])
    else $error("low power while regulator off");
  a_sw_run_lp: assert property (
    pmic_state == ST_RUN |=> !s_q.lp[1])
    else $error("switchable LDO low power in run");
  a_sw_standby: assert property (
    pmic_state == ST_STANDBY && !s_q.cfg[1][`CFG_STBY] |=> !s_q.on[1])
    else $error("switchable LDO on in standby without keep");

  c_scp_trip: cover property (s_q.scp_en && oc_eff[0] ##1 irq);
  c_cell_handover: cover property (backup_from_rail ##[1:20] backup_from_cell);
  c_lp_sleep: cover property (pmic_state == ST_SLEEP && s_q.lp[2]);
  c_fault_clear: cover property (s_q.fault[1] ##1 !s_q.fault[1]);
  c_load_switch: cover property (s_q.full_on[1] && s_q.soft_start[1]);

endmodule // ldo_control_fault_logic
`default_nettype wire

// ==== testbench/host_cpu_model.sv ====
// Purpose: system processor side of the register bus, an Avalon-MM master
// Assumes: one request at a time; the slave answers by dropping waitrequest
// Notes: the bench calls bus_xfer hierarchically; released address and data lines show inverted values
`timescale 1ns/1ps
`default_nettype none
`include "ldo_ctrl_defines.svh"
module host_cpu_model
  import ldo_ctrl_pkg::*;
(
  input wire logic core_clk,
  output logic [`ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  // ------------------------------------------------------------
  // idle bus at time zero
  // ------------------------------------------------------------
  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
  end

  // ------------------------------------------------------------
  // one transfer: hold everything until waitrequest is seen low
  // ------------------------------------------------------------
  // no cycle count is assumed; a dead slave is caught by the bench watchdog
  task automatic bus_xfer(input logic is_wr, input logic [`ADDR_W-1:0] a,
                          input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    @(posedge core_clk);
    address <= a;
    writedata <= wd;
    write <= is_wr;
    read <= !is_wr;
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    ok = !$isunknown(readdata);
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a; // stale values must not look like a valid request
    writedata <= ~wd;
  endtask
endmodule // host_cpu_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for the LDO control and fault block
// Assumes: one wait state per access, mode outputs settle within three cycles
// Notes: expectations come from the mode table, voltage steps and fault rules
`timescale 1ns/1ps
`default_nettype none
`include "ldo_ctrl_defines.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %0t got %h want %h", $time, a, e); end end
module tb_top
  import ldo_ctrl_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [`ADDR_W-1:0] address;
  logic read, write, waitrequest, irq;
  logic [31:0] writedata, readdata, d;
  pmic_state_t pmic_state = ST_RUN;
  logic [2:0] over_current = '0;
  logic host_reset_output_n = 1'b1;
  logic rail_above_upper = 1'b0, rail_below_lower = 1'b0, backup_cell_present = 1'b0;
  logic [2:0] ldo_on, ldo_low_power, current_limit_en, pass_full_on, soft_start_pulse, ldo_discharge;
  logic [3:0] fixed_ldo_voltage_code;
  logic [11:0] fixed_ldo_millivolt;
  logic backup_from_rail, backup_from_cell, backup_switch_mode, ss_seen, ok, on, lp;
  int n_mismatch = 0;
  int tests_run = 0;

  // ------------------------------------------------------------
  // clock, partner and design
  // ------------------------------------------------------------
  always #5 core_clk = ~core_clk;
  // soft-start pulse lasts one cycle, so latch it for later checking
  always @(posedge core_clk) if (soft_start_pulse[1]) ss_seen <= 1'b1;
  host_cpu_model cpu (.core_clk(core_clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  ldo_control_fault_logic dut (.core_clk(core_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .pmic_state(pmic_state), .over_current(over_current),
    .host_reset_output_n(host_reset_output_n), .rail_above_upper(rail_above_upper),
    .rail_below_lower(rail_below_lower), .backup_cell_present(backup_cell_present),
    .ldo_on(ldo_on), .ldo_low_power(ldo_low_power), .current_limit_en(current_limit_en),
    .pass_full_on(pass_full_on), .soft_start_pulse(soft_start_pulse),
    .ldo_discharge(ldo_discharge), .fixed_ldo_voltage_code(fixed_ldo_voltage_code),
    .fixed_ldo_millivolt(fixed_ldo_millivolt), .backup_from_rail(backup_from_rail),
    .backup_from_cell(backup_from_cell), .backup_switch_mode(backup_switch_mode), .irq(irq));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] v);
    logic [31:0] x;
    cpu.bus_xfer(1'b1, a, v, x, ok);
    if (!ok) n_mismatch++;
  endtask
  task automatic rg(input logic [`ADDR_W-1:0] a);
    cpu.bus_xfer(1'b0, a, 32'h0000_0000, d, ok);
    if (!ok) n_mismatch++;
  endtask
  // one overload pulse, then time for flag and irq to land
  task automatic overload(input logic [2:0] m, input int len);
    over_current <= m;
    tick(len);
    over_current <= '0;
    tick(3);
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100us;
    n_mismatch++;
    end_sim;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    ss_seen = 1'b0;
    tick(20);
    rst <= 1'b0;
    rg(`REG_CTRL);
    `CHK(d[0], 1'b0)
    rg(5'h1c);
    `CHK(d, 32'h0000_0000) // unmapped reads as zero
    // voltage code walks every step
    for (int c = 0; c < 16; c++) begin
      wr(`REG_FIXED, 32'(c << 4));
      tick(3);
      `CHK(fixed_ldo_millivolt, 12'(1800 + 100 * c))
      `CHK(fixed_ldo_voltage_code, 4'(c))
      rg(`REG_STATUS);
      `CHK(d[31:20], 12'(1800 + 100 * c))
    end
    // full mode table for all three regulators and all states
    for (int i = 0; i < 3; i++) begin
      for (int s = 0; s < 3; s++) begin
        pmic_state <= pmic_state_t'(s);
        for (int c = 0; c < 16; c++) begin
          wr(5'(4 * (i + 1)), 32'(c));
          tick(3);
          on = c[0] && (s == 0 || (s == 1 && c[1]) || (s == 2 && c[2]));
          lp = on && s != 0 && c[3];
          `CHK(ldo_on[i], on)
          `CHK(ldo_low_power[i], lp)
          `CHK(ldo_discharge[i], !on)
        end
      end
    end
    pmic_state <= ST_RUN;
    wr(`REG_FIXED, 32'h0000_0001);
    host_reset_output_n <= 1'b0;
    tick(3);
    `CHK(ldo_discharge[2], 1'b1)
    host_reset_output_n <= 1'b1;
    // overload with protection off: stays on, flagged until read
    wr(`REG_SW_A, 32'h0000_0001);
    tick(3);
    overload(3'b001, 2);
    `CHK(ldo_on[0], 1'b1)
    `CHK(current_limit_en[0], 1'b1)
    `CHK(irq, 1'b1)
    rg(`REG_FAULT);
    `CHK(d[2:0], 3'b001)
    rg(`REG_FAULT);
    `CHK(d[2:0], 3'b000)
    `CHK(irq, 1'b0)
    // masked overload sets the flag but keeps irq low
    wr(`REG_MASK, 32'h0000_0001);
    overload(3'b001, 2);
    `CHK(irq, 1'b0)
    rg(`REG_FAULT);
    `CHK(d[2:0], 3'b001)
    wr(`REG_MASK, 32'h0000_0000);
    // protection on: each regulator is switched off and flagged
    wr(`REG_CTRL, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      wr(5'(4 * (i + 1)), 32'h0000_0001);
      tick(3);
      overload(3'(1 << i), 1);
      `CHK(ldo_on[i], 1'b0)
      rg(5'(4 * (i + 1)));
      `CHK(d[0], 1'b0)
      rg(`REG_FAULT);
      `CHK(d[i], 1'b1)
    end
    // load switch: fully on, soft-started, no limiter, no flag
    wr(`REG_CTRL, 32'h0000_0000);
    ss_seen <= 1'b0;
    wr(`REG_SW_B, 32'h0000_0011);
    tick(4);
    `CHK(ss_seen, 1'b1)
    `CHK(pass_full_on[1], 1'b1)
    `CHK(current_limit_en[1], 1'b0)
    overload(3'b010, 2);
    rg(`REG_FAULT);
    `CHK(d[1], 1'b0)
    // backup source with the cell enabled, then disabled
    wr(`REG_CTRL, 32'h0000_0002);
    rail_above_upper <= 1'b1;
    backup_cell_present <= 1'b1;
    tick(3);
    `CHK(backup_from_rail, 1'b1)
    rail_above_upper <= 1'b0;
    rail_below_lower <= 1'b1;
    tick(3);
    `CHK(backup_from_cell, 1'b1)
    `CHK(backup_switch_mode, 1'b1)
    wr(`REG_CTRL, 32'h0000_0000);
    rail_below_lower <= 1'b0;
    rail_above_upper <= 1'b1;
    tick(3);
    rail_above_upper <= 1'b0;
    rail_below_lower <= 1'b1;
    tick(3);
    `CHK(backup_from_cell, 1'b0)
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
